/* File: rtl/scpi_error_queue_status_clear.sv */
// scpi_error_queue_status_clear: error queue, event registers and opc logic
// assumes a command decoder on the same clock delivering one-cycle strobes
// What this block does
// - clear-status zeroes status summary and standard, operation, meas, quest events
// - opc query answers 1 only after pending operations have finished
// - error entries come back oldest first
// - each read of an entry removes it from the queue
// - at most ten entries; the next error overwrites newest with overflow
// - after overflow is stored, further errors are dropped until cleared
// - reading an empty queue returns +000 and changes nothing
// - system-clear or power-up empties the whole queue
// - instrument reset leaves the queue untouched
// - header faults log -111, -112, -113
// - out-of-range parameter logs -221, illegal value logs -223
// - numeric faults log -121, -123, -124
// - character faults log -141 and -144
// - query faults log -410, -420, -440
// - measurement events log +301, +302, +310
// - protection events log +320, +321, +409, +410
// - lost nonvolatile content logs +512, +514, +515
// - reading the standard event register clears it after returning it
`default_nettype none
module scpi_error_queue_status_clear
  import errq_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // commands from the decoder
  input  wire status_cmd_e           status_cmd,
  input  wire queue_cmd_e            queue_cmd,
  input  wire logic                  pending_busy,
  // fault and event reports, one-cycle strobes, only the lowest index is logged
  input  wire logic [NUM_FAULTS-1:0] fault_strobe,
  // raw event sources for the standard and other event registers and the summary
  input  wire logic [7:0]            std_event_set,
  input  wire logic [7:0]            oper_event_set,
  input  wire logic [7:0]            meas_event_set,
  input  wire logic [7:0]            quest_event_set,
  input  wire logic                  summary_set,
  // error queue read
  input  wire logic                  err_read_req,
  output logic                       err_read_ack,
  output logic      [CODE_W-1:0]     err_read_code,
  // standard event register read
  input  wire logic                  std_read_req,
  output logic                       std_read_ack,
  output logic      [7:0]            std_read_value,
  // opc query reply to output queue
  output logic                       opc_reply_valid,
  output logic      [CODE_W-1:0]     opc_reply_value,
  // event register and status views
  output logic      [7:0]            oper_event,
  output logic      [7:0]            meas_event,
  output logic      [7:0]            quest_event,
  output logic                       status_summary,
  output logic      [PTR_W-1:0]      err_count
);
  typedef struct packed {
    opc_state_e         opc_st;
    logic [7:0]         std_ev;
    logic [7:0]         oper_ev;
    logic [7:0]         meas_ev;
    logic [7:0]         quest_ev;
    logic               summary;
    logic               locked;
    logic               err_ack;
    logic [CODE_W-1:0]  err_code;
    logic               std_ack;
    logic [7:0]         std_val;
    logic               opc_valid;
  } ctl_s;
  ctl_s ctl_reg;
  ctl_s ctl_next;

  logic [CODE_W-1:0] head_code;
  logic [PTR_W-1:0]  count;
  logic              q_clear;
  logic              q_push;
  logic              q_pop;
  logic              q_replace;
  logic [CODE_W-1:0] q_code;
  logic              fault_any;
  logic [CODE_W-1:0] fault_code;

  // lowest strobed source wins when several arrive together
  function automatic logic [CODE_W-1:0] code_of(input int unsigned idx);
    case (idx)
      0:  return CODE_HDR_SEPARATOR;
      1:  return CODE_HDR_TOO_LONG;
      2:  return CODE_HDR_UNDEFINED;
      3:  return CODE_PAR_RANGE;
      4:  return CODE_PAR_ILLEGAL;
      5:  return CODE_NUM_BAD_CHAR;
      6:  return CODE_NUM_EXPONENT;
      7:  return CODE_NUM_DIGITS;
      8:  return CODE_CHR_INVALID;
      9:  return CODE_CHR_TOO_LONG;
      10: return CODE_QRY_UNTERM;
      11: return CODE_QRY_DEADLOCK;
      12: return CODE_QRY_INDEF;
      13: return CODE_READ_OVERFLOW;
      14: return CODE_PULSE_TIMEOUT;
      15: return CODE_BUFFER_FULL;
      16: return CODE_CURR_LIMIT;
      17: return CODE_CURR_TRIPPED;
      18: return CODE_OVER_TEMP;
      19: return CODE_OVER_VOLTAGE;
      20: return CODE_POWERON_LOST;
      21: return CODE_DCCAL_LOST;
      22: return CODE_CALDATE_LOST;
      default: return CODE_NO_ERROR;
    endcase
  endfunction

  always_comb begin
    fault_any  = 1'b0;
    fault_code = CODE_NO_ERROR;
    for (int i = NUM_FAULTS - 1; i >= 0; i--) begin
      if (fault_strobe[i]) begin
        fault_any  = 1'b1;
        fault_code = code_of(i);
      end
    end
  end

  // queue control
  always_comb begin
    q_clear   = (queue_cmd == CMD_SYSTEM_CLEAR);
    q_pop     = err_read_req && !ctl_reg.err_ack
                && count != '0 && !q_clear;
    q_push    = 1'b0;
    q_replace = 1'b0;
    q_code    = fault_code;
    if (fault_any && !q_clear && !ctl_reg.locked) begin
      if (count < PTR_W'(QUEUE_DEPTH) || q_pop) begin
        q_push = 1'b1;
      end else begin
        q_replace = 1'b1;
        q_code    = CODE_QUEUE_OVERFLOW;
      end
    end
  end

  errq_store u_store (
    .clk          (clk),
    .reset        (reset),
    .clear        (q_clear),
    .push         (q_push),
    .pop          (q_pop),
    .replace_last (q_replace),
    .push_code    (q_code),
    .head_code    (head_code),
    .count        (count)
  );

  always_comb begin
    ctl_next           = ctl_reg;
    ctl_next.err_ack   = 1'b0;
    ctl_next.std_ack   = 1'b0;
    ctl_next.opc_valid = 1'b0;
    // error queue read answer
    if (err_read_req && !ctl_reg.err_ack) begin
      ctl_next.err_ack  = 1'b1;
      ctl_next.err_code = (count != '0) ? head_code : CODE_NO_ERROR;
    end
    if (q_replace) ctl_next.locked = 1'b1;
    if (q_clear) ctl_next.locked = 1'b0;
    // event registers accumulate, set wins over clear
    ctl_next.oper_ev  = oper_event_set;
    ctl_next.meas_ev  = meas_event_set;
    ctl_next.quest_ev = quest_event_set;
    ctl_next.summary  = summary_set;
    if (status_cmd != CMD_CLEAR_STATUS) begin
      ctl_next.oper_ev  = ctl_reg.oper_ev | oper_event_set;
      ctl_next.meas_ev  = ctl_reg.meas_ev | meas_event_set;
      ctl_next.quest_ev = ctl_reg.quest_ev | quest_event_set;
      ctl_next.summary  = ctl_reg.summary | summary_set;
    end
    // standard event register: read returns then clears
    if (std_read_req && !ctl_reg.std_ack) begin
      ctl_next.std_ack = 1'b1;
      ctl_next.std_val = ctl_reg.std_ev;
      ctl_next.std_ev  = std_event_set;
    end else if (status_cmd == CMD_CLEAR_STATUS) begin
      ctl_next.std_ev  = std_event_set;
    end else begin
      ctl_next.std_ev  = ctl_reg.std_ev | std_event_set;
    end
    // operation complete handling
    case (ctl_reg.opc_st)
      OPC_IDLE: begin
        if (status_cmd == CMD_OPC) ctl_next.opc_st = OPC_WAIT_SET;
        if (status_cmd == CMD_OPC_QUERY) ctl_next.opc_st = OPC_WAIT_REPLY;
      end
      OPC_WAIT_SET: begin
        if (!pending_busy) begin
          ctl_next.std_ev[OPC_BIT] = 1'b1;
          ctl_next.opc_st          = OPC_IDLE;
        end
      end
      OPC_WAIT_REPLY: begin
        if (!pending_busy) begin
          ctl_next.opc_valid = 1'b1;
          ctl_next.opc_st    = OPC_IDLE;
        end
      end
      default: ctl_next.opc_st = OPC_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_reg          <= '0;
      ctl_reg.opc_st   <= OPC_IDLE;
      ctl_reg.std_ev   <= EVENT_RESET;
      ctl_reg.err_code <= CODE_NO_ERROR;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign err_read_ack    = ctl_reg.err_ack;
  assign err_read_code   = ctl_reg.err_code;
  assign std_read_ack    = ctl_reg.std_ack;
  assign std_read_value  = ctl_reg.std_val;
  assign opc_reply_valid = ctl_reg.opc_valid;
  assign opc_reply_value = OPC_REPLY;
  assign oper_event      = ctl_reg.oper_ev;
  assign meas_event      = ctl_reg.meas_ev;
  assign quest_event     = ctl_reg.quest_ev;
  assign status_summary  = ctl_reg.summary;
  assign err_count       = count;

  // checks
  empty_read_a: assert property (@(posedge clk) disable iff (reset)
    err_read_req && !err_read_ack && count == '0 && queue_cmd == CMD_OTHER
    && !fault_any |=> err_read_code == CODE_NO_ERROR && count == '0)
    else $error("empty read did not return no-error");
  read_pop_a: assert property (@(posedge clk) disable iff (reset)
    q_pop && !fault_any |=> count == $past(count) - 1'b1)
    else $error("read did not remove entry");
  depth_cap_a: assert property (@(posedge clk) disable iff (reset)
    count <= PTR_W'(QUEUE_DEPTH))
    else $error("queue exceeds ten entries");
  overflow_mark_a: assert property (@(posedge clk) disable iff (reset)
    q_replace |=> ctl_reg.locked)
    else $error("overflow did not lock queue");
  locked_drop_a: assert property (@(posedge clk) disable iff (reset)
    ctl_reg.locked && queue_cmd != CMD_SYSTEM_CLEAR && !q_pop
    |=> count == $past(count))
    else $error("error accepted while locked");
  sys_clear_a: assert property (@(posedge clk) disable iff (reset)
    queue_cmd == CMD_SYSTEM_CLEAR |=> count == '0)
    else $error("system clear left entries");
  rst_keep_a: assert property (@(posedge clk) disable iff (reset)
    queue_cmd == CMD_INSTRUMENT_RESET && !fault_any && !q_pop
    |=> count == $past(count))
    else $error("instrument reset changed queue");
  cls_zero_a: assert property (@(posedge clk) disable iff (reset)
    status_cmd == CMD_CLEAR_STATUS && oper_event_set == '0
    && quest_event_set == '0 |=> oper_event == '0 && quest_event == '0)
    else $error("clear status left events");
  opc_wait_a: assert property (@(posedge clk) disable iff (reset)
    opc_reply_valid |-> !$past(pending_busy))
    else $error("opc reply while busy");
  std_clear_a: assert property (@(posedge clk) disable iff (reset)
    std_read_req && !std_read_ack && std_event_set == '0
    && ctl_reg.opc_st != OPC_WAIT_SET |=> ctl_reg.std_ev == '0)
    else $error("standard event not cleared on read");

  // reset and handshake checks
  reset_clear_a: assert property (@(posedge clk)
    reset
    |=> count == '0 && ctl_reg.std_ev == '0 && !status_summary)
    else $error("reset left state behind");
  ack_pulse_a: assert property (@(posedge clk) disable iff (reset)
    err_read_ack
    |=> !err_read_ack)
    else $error("error read ack held too long");
  std_pulse_a: assert property (@(posedge clk) disable iff (reset)
    std_read_ack
    |=> !std_read_ack)
    else $error("event read ack held too long");
  std_value_a: assert property (@(posedge clk) disable iff (reset)
    std_read_req && !std_read_ack
    |=> std_read_value == $past(ctl_reg.std_ev))
    else $error("event read returned wrong value");

  // queue checks
  fifo_head_a: assert property (@(posedge clk) disable iff (reset)
    q_pop
    |=> err_read_code == $past(head_code))
    else $error("read did not return oldest entry");
  push_count_a: assert property (@(posedge clk) disable iff (reset)
    q_push && !q_pop
    |=> count == $past(count) + 1'b1)
    else $error("logged error not added");
  full_replace_a: assert property (@(posedge clk) disable iff (reset)
    q_replace
    |=> count == PTR_W'(QUEUE_DEPTH))
    else $error("overflow changed entry count");
  unlock_a: assert property (@(posedge clk) disable iff (reset)
    q_clear
    |=> !ctl_reg.locked)
    else $error("system clear left queue locked");
  rst_lock_a: assert property (@(posedge clk) disable iff (reset)
    queue_cmd == CMD_INSTRUMENT_RESET && !q_replace
    |=> ctl_reg.locked == $past(ctl_reg.locked))
    else $error("instrument reset changed lock");

  // logged code checks
  hdr_code_a: assert property (@(posedge clk) disable iff (reset)
    fault_strobe[0] && count == '0 && !q_clear && !ctl_reg.locked
    |=> head_code == CODE_HDR_SEPARATOR)
    else $error("header fault logged with wrong code");
  prot_code_a: assert property (@(posedge clk) disable iff (reset)
    fault_strobe[19] && fault_strobe[18:0] == '0 && count == '0
    && !q_clear && !ctl_reg.locked |=> head_code == CODE_OVER_VOLTAGE)
    else $error("protection event logged with wrong code");
  nvm_code_a: assert property (@(posedge clk) disable iff (reset)
    fault_strobe[22] && fault_strobe[21:0] == '0 && count == '0
    && !q_clear && !ctl_reg.locked |=> head_code == CODE_CALDATE_LOST)
    else $error("lost content logged with wrong code");

  // status and opc checks
  cls_summary_a: assert property (@(posedge clk) disable iff (reset)
    status_cmd == CMD_CLEAR_STATUS && !summary_set && meas_event_set == '0
    |=> !status_summary && meas_event == '0)
    else $error("clear status left summary or events");
  opc_hold_a: assert property (@(posedge clk) disable iff (reset)
    ctl_reg.opc_st == OPC_WAIT_SET && pending_busy
    |=> ctl_reg.opc_st == OPC_WAIT_SET)
    else $error("opc finished while busy");
  opc_set_a: assert property (@(posedge clk) disable iff (reset)
    ctl_reg.opc_st == OPC_WAIT_SET && !pending_busy
    |=> ctl_reg.std_ev[OPC_BIT] && ctl_reg.opc_st == OPC_IDLE)
    else $error("opc did not set complete bit");
  opc_reply_a: assert property (@(posedge clk) disable iff (reset)
    ctl_reg.opc_st == OPC_WAIT_REPLY && !pending_busy
    |=> opc_reply_valid && opc_reply_value == OPC_REPLY)
    else $error("opc query not answered");
  overflow_c: cover property (@(posedge clk) q_replace);
  opc_reply_c: cover property (@(posedge clk) opc_reply_valid);
  full_read_c: cover property (@(posedge clk)
    count == PTR_W'(QUEUE_DEPTH) ##1 q_pop);
  lock_clear_c: cover property (@(posedge clk) ctl_reg.locked && q_clear);
  opc_set_c: cover property (@(posedge clk)
    ctl_reg.opc_st == OPC_WAIT_SET && !pending_busy);
endmodule // scpi_error_queue_status_clear
`default_nettype wire

/* File: rtl/errq_pkg.sv */
// errq_pkg: constants and types shared by the error queue and its storage
// assumes a single 200 MHz clock domain
`default_nettype none
package errq_pkg;
  localparam int unsigned QUEUE_DEPTH = 10;
  localparam int unsigned PTR_W       = 4;
  localparam int unsigned CODE_W      = 16;
  // error codes, two's complement
  localparam logic [15:0] CODE_NO_ERROR       = 16'h0000;
  localparam logic [15:0] CODE_QUEUE_OVERFLOW = 16'hFEB6; // -330
  localparam logic [15:0] CODE_HDR_SEPARATOR  = 16'hFF91; // -111
  localparam logic [15:0] CODE_HDR_TOO_LONG   = 16'hFF90; // -112
  localparam logic [15:0] CODE_HDR_UNDEFINED  = 16'hFF8F; // -113
  localparam logic [15:0] CODE_NUM_BAD_CHAR   = 16'hFF87; // -121
  localparam logic [15:0] CODE_NUM_EXPONENT   = 16'hFF85; // -123
  localparam logic [15:0] CODE_NUM_DIGITS     = 16'hFF84; // -124
  localparam logic [15:0] CODE_CHR_INVALID    = 16'hFF73; // -141
  localparam logic [15:0] CODE_CHR_TOO_LONG   = 16'hFF70; // -144
  localparam logic [15:0] CODE_PAR_RANGE      = 16'hFF23; // -221
  localparam logic [15:0] CODE_PAR_ILLEGAL    = 16'hFF21; // -223
  localparam logic [15:0] CODE_QRY_UNTERM     = 16'hFE66; // -410
  localparam logic [15:0] CODE_QRY_DEADLOCK   = 16'hFE5C; // -420
  localparam logic [15:0] CODE_QRY_INDEF      = 16'hFE48; // -440
  localparam logic [15:0] CODE_READ_OVERFLOW  = 16'h012D; // +301
  localparam logic [15:0] CODE_PULSE_TIMEOUT  = 16'h012E; // +302
  localparam logic [15:0] CODE_BUFFER_FULL    = 16'h0136; // +310
  localparam logic [15:0] CODE_CURR_LIMIT     = 16'h0140; // +320
  localparam logic [15:0] CODE_CURR_TRIPPED   = 16'h0141; // +321
  localparam logic [15:0] CODE_OVER_TEMP      = 16'h0199; // +409
  localparam logic [15:0] CODE_OVER_VOLTAGE   = 16'h019A; // +410
  localparam logic [15:0] CODE_POWERON_LOST   = 16'h0200; // +512
  localparam logic [15:0] CODE_DCCAL_LOST     = 16'h0202; // +514
  localparam logic [15:0] CODE_CALDATE_LOST   = 16'h0203; // +515
  // fault sources, one-hot position in the fault strobe vector
  localparam int unsigned NUM_FAULTS = 23;
  localparam int unsigned OPC_BIT    = 0;
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic [15:0] OPC_REPLY  = 16'h0001;
  typedef enum logic [1:0] {
    CMD_NONE, CMD_CLEAR_STATUS, CMD_OPC, CMD_OPC_QUERY
  } status_cmd_e;
  typedef enum logic [1:0] {
    CMD_OTHER, CMD_SYSTEM_CLEAR, CMD_INSTRUMENT_RESET
  } queue_cmd_e;
  typedef enum {OPC_IDLE, OPC_WAIT_SET, OPC_WAIT_REPLY} opc_state_e;
endpackage
`default_nettype wire

/* File: rtl/errq_store.sv */
// errq_store: ten-entry flip-flop storage for error codes, fifo order
// assumes the caller pushes when full only with a pop in the same cycle and never pops when empty
`default_nettype none
module errq_store
  import errq_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // control
  input  wire logic              clear,
  input  wire logic              push,
  input  wire logic              pop,
  input  wire logic              replace_last,
  input  wire logic [CODE_W-1:0] push_code,
  // status and head
  output logic      [CODE_W-1:0] head_code,
  output logic      [PTR_W-1:0]  count
);
  typedef struct packed {
    logic [QUEUE_DEPTH-1:0][CODE_W-1:0] mem;
    logic [PTR_W-1:0]                   rd;
    logic [PTR_W-1:0]                   cnt;
  } store_s;
  store_s st_reg;
  store_s st_next;

  function automatic logic [PTR_W-1:0] wrap_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(QUEUE_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  function automatic logic [PTR_W-1:0] slot(input logic [PTR_W-1:0] base,
                                            input logic [PTR_W-1:0] off);
    logic [PTR_W:0] s;
    s = {1'b0, base} + {1'b0, off};
    if (s >= (PTR_W+1)'(QUEUE_DEPTH)) s = s - (PTR_W+1)'(QUEUE_DEPTH);
    return s[PTR_W-1:0];
  endfunction

  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next.rd  = '0;
      st_next.cnt = '0;
    end else begin
      if (replace_last && st_reg.cnt != '0)
        st_next.mem[slot(st_reg.rd, st_reg.cnt - 1'b1)] = push_code;
      else if (push)
        st_next.mem[slot(st_reg.rd, st_reg.cnt)] = push_code;
      if (pop) st_next.rd = wrap_inc(st_reg.rd);
      st_next.cnt = st_reg.cnt + PTR_W'(push) - PTR_W'(pop);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign head_code = st_reg.mem[st_reg.rd];
  assign count     = st_reg.cnt;
endmodule // errq_store
`default_nettype wire

/* File: dv/host_model.sv */
// host_model: remote host that reads the error queue and standard events
// assumes one clock; requests change 1 ns after a rising edge
`default_nettype none
module host_model
  import errq_pkg::*;
(
  // clock
  input  wire logic              clk,
  // error queue read
  output logic                   err_read_req,
  input  wire logic              err_read_ack,
  input  wire logic [CODE_W-1:0] err_read_code,
  // standard event read
  output logic                   std_read_req,
  input  wire logic              std_read_ack,
  input  wire logic [7:0]        std_read_value
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    err_read_req = 1'b0;
    std_read_req = 1'b0;
  end

  // idle for lag + 1 clock edges, then hold the request until ack is sampled
  task automatic read_err(input int lag, output logic [CODE_W-1:0] code,
                          output bit ok);
    ok = 1'b0;
    repeat (lag + 1) @(posedge clk);
    #1 err_read_req = 1'b1;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge clk);
      ok = (err_read_ack === 1'b1);
    end
    code = err_read_code;
    #1 err_read_req = 1'b0;
  endtask

  task automatic read_std(input int lag, output logic [7:0] value,
                          output bit ok);
    ok = 1'b0;
    repeat (lag + 1) @(posedge clk);
    #1 std_read_req = 1'b1;
    for (int n = 0; n < 16 && !ok; n++) begin
      @(posedge clk);
      ok = (std_read_ack === 1'b1);
    end
    value = std_read_value;
    #1 std_read_req = 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

/* File: dv/tb_top.sv */
// tb_top: self-checking bench for the error queue and status block
// assumes errq_pkg, the design and host_model are compiled first
`default_nettype none
module tb_top
  import errq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [CODE_W-1:0] CODES [NUM_FAULTS] = '{
    CODE_HDR_SEPARATOR, CODE_HDR_TOO_LONG, CODE_HDR_UNDEFINED,
    CODE_PAR_RANGE, CODE_PAR_ILLEGAL, CODE_NUM_BAD_CHAR, CODE_NUM_EXPONENT,
    CODE_NUM_DIGITS, CODE_CHR_INVALID, CODE_CHR_TOO_LONG, CODE_QRY_UNTERM,
    CODE_QRY_DEADLOCK, CODE_QRY_INDEF, CODE_READ_OVERFLOW, CODE_PULSE_TIMEOUT,
    CODE_BUFFER_FULL, CODE_CURR_LIMIT, CODE_CURR_TRIPPED, CODE_OVER_TEMP,
    CODE_OVER_VOLTAGE, CODE_POWERON_LOST, CODE_DCCAL_LOST,
    CODE_CALDATE_LOST};

  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  status_cmd_e           status_cmd = CMD_NONE;
  queue_cmd_e            queue_cmd = CMD_OTHER;
  logic                  pending_busy = 1'b0;
  logic [NUM_FAULTS-1:0] fault_strobe = '0;
  logic [7:0]            std_set = '0, oper_set = '0;
  logic [7:0]            meas_set = '0, quest_set = '0;
  logic                  summary_set = 1'b0;
  logic                  err_read_req, err_read_ack, std_read_req;
  logic                  std_read_ack, opc_reply_valid, status_summary;
  logic [CODE_W-1:0]     err_read_code, opc_reply_value;
  logic [7:0]            std_read_value, oper_event, meas_event, quest_event;
  logic [PTR_W-1:0]      err_count;
  logic [CODE_W-1:0]     q[$];
  logic                  locked = 1'b0;
  logic                  seen;
  logic [7:0]            ov;
  int                    fail_count = 0;
  int                    checks = 0;
  integer                seed = 32'h4EFF;

  always #2.5 clk = ~clk;

  scpi_error_queue_status_clear uut (
    .clk(clk), .reset(reset), .status_cmd(status_cmd),
    .queue_cmd(queue_cmd), .pending_busy(pending_busy),
    .fault_strobe(fault_strobe), .std_event_set(std_set),
    .oper_event_set(oper_set), .meas_event_set(meas_set),
    .quest_event_set(quest_set), .summary_set(summary_set),
    .err_read_req(err_read_req), .err_read_ack(err_read_ack),
    .err_read_code(err_read_code), .std_read_req(std_read_req),
    .std_read_ack(std_read_ack), .std_read_value(std_read_value),
    .opc_reply_valid(opc_reply_valid), .opc_reply_value(opc_reply_value),
    .oper_event(oper_event), .meas_event(meas_event),
    .quest_event(quest_event), .status_summary(status_summary),
    .err_count(err_count));

  host_model host (
    .clk(clk), .err_read_req(err_read_req), .err_read_ack(err_read_ack),
    .err_read_code(err_read_code), .std_read_req(std_read_req),
    .std_read_ack(std_read_ack), .std_read_value(std_read_value));

  task automatic print_verdict();
    if (fail_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [CODE_W-1:0] exp,
                     input logic [CODE_W-1:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic timeout_hit(input bit ok);
    if (!ok) begin
      fail_count++;
      $display("mismatch read_ack expected 1 seen 0");
      print_verdict();
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // expected queue after one logged fault
  function automatic void model_push(input logic [CODE_W-1:0] c);
    if (locked) return;
    if (q.size() < QUEUE_DEPTH) q.push_back(c);
    else begin
      q[QUEUE_DEPTH-1] = CODE_QUEUE_OVERFLOW;
      locked = 1'b1;
    end
  endfunction

  task automatic report_fault(input int i, input int j);
    logic [NUM_FAULTS-1:0] v;
    v = '0;
    v[i] = 1'b1;
    v[j] = 1'b1;
    fault_strobe = v;
    step(1);
    fault_strobe = '0;
    step(1);
    model_push(CODES[i < j ? i : j]);
    chk("err_count", 16'(q.size()), {12'h000, err_count});
  endtask

  task automatic rd_chk();
    logic [CODE_W-1:0] c;
    logic [CODE_W-1:0] e;
    bit                ok;
    e = (q.size() > 0) ? q.pop_front() : CODE_NO_ERROR;
    host.read_err($unsigned($random(seed)) % 3, c, ok);
    timeout_hit(ok);
    chk("err_read_code", e, c);
    chk("err_count", 16'(q.size()), {12'h000, err_count});
  endtask

  task automatic std_chk(input logic [7:0] e);
    logic [7:0] v;
    bit         ok;
    host.read_std($unsigned($random(seed)) % 3, v, ok);
    timeout_hit(ok);
    chk("std_read_value", {8'h00, e}, {8'h00, v});
  endtask

  task automatic cmd(input status_cmd_e s, input queue_cmd_e c);
    status_cmd = s;
    queue_cmd = c;
    step(1);
    status_cmd = CMD_NONE;
    queue_cmd = CMD_OTHER;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1 reset = 1'b0;
    chk("err_count", 16'h0000, {12'h000, err_count});
    rd_chk();
    for (int i = 0; i < NUM_FAULTS; i++) begin
      report_fault(i, i);
      rd_chk();
    end
    report_fault(7, 3);
    repeat (6) report_fault($unsigned($random(seed)) % NUM_FAULTS, 21);
    repeat (8) rd_chk();
    for (int i = 0; i < 12; i++) report_fault(i, i);
    cmd(CMD_NONE, CMD_INSTRUMENT_RESET);
    chk("err_count", 16'h000A, {12'h000, err_count});
    report_fault(2, 2);
    repeat (10) rd_chk();
    report_fault(4, 4);
    cmd(CMD_NONE, CMD_SYSTEM_CLEAR);
    locked = 1'b0;
    report_fault(9, 9);
    rd_chk();
    pending_busy = 1'b1;
    cmd(CMD_OPC_QUERY, CMD_OTHER);
    seen = 1'b0;
    repeat (6) begin
      step(1);
      seen = seen | opc_reply_valid;
    end
    chk("opc_reply_valid", 16'h0000, {15'h0000, seen});
    pending_busy = 1'b0;
    repeat (4) begin
      step(1);
      if (opc_reply_valid === 1'b1) begin
        seen = 1'b1;
        chk("opc_reply_value", OPC_REPLY, opc_reply_value);
      end
    end
    chk("opc_reply_valid", 16'h0001, {15'h0000, seen});
    pending_busy = 1'b1;
    cmd(CMD_OPC, CMD_OTHER);
    step(3);
    std_chk(8'h00);
    pending_busy = 1'b0;
    step(3);
    std_chk(8'h01);
    std_chk(8'h00);
    ov = 8'($random(seed)) | 8'h80;
    std_set = ov;
    oper_set = ov;
    meas_set = ~ov;
    quest_set = ov ^ 8'h3C;
    summary_set = 1'b1;
    step(1);
    {std_set, oper_set, meas_set, quest_set, summary_set} = '0;
    chk("oper_event", {8'h00, ov}, {8'h00, oper_event});
    chk("meas_event", {8'h00, ~ov}, {8'h00, meas_event});
    chk("quest_event", {8'h00, ov ^ 8'h3C}, {8'h00, quest_event});
    chk("status_summary", 16'h0001, {15'h0000, status_summary});
    cmd(CMD_CLEAR_STATUS, CMD_OTHER);
    chk("events", 16'h0000, {oper_event | meas_event | quest_event, 8'h00});
    chk("status_summary", 16'h0000, {15'h0000, status_summary});
    std_chk(8'h00);
    report_fault(1, 1);
    oper_set = 8'h5A;
    step(1);
    oper_set = 8'h00;
    reset = 1'b1;
    step(2);
    reset = 1'b0;
    q.delete();
    chk("err_count", 16'h0000, {12'h000, err_count});
    chk("oper_event", 16'h0000, {8'h00, oper_event});
    rd_chk();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
